// [hw_status_consts.svh]
// constants for the first equipment status group: command codes, bit positions, reset values
`ifndef HW_STATUS_CONSTS_SVH
`define HW_STATUS_CONSTS_SVH

// register width
`define STAT_WIDTH 16

// status command codes on the command port
`define CMD_RD_COND 3'h0
`define CMD_RD_RISE 3'h1
`define CMD_WR_RISE 3'h2
`define CMD_RD_FALL 3'h3
`define CMD_WR_FALL 3'h4
`define CMD_RD_EVNT 3'h5
`define CMD_RD_MASK 3'h6
`define CMD_WR_MASK 3'h7

// condition bit positions
`define BIT_ALWAYS_ZERO 15
`define BIT_RADIO_IRQ2 14
`define BIT_RADIO_IRQ1 13
`define BIT_DEC_RESULTS 12
`define BIT_DEC_LOW_LEVEL 11
`define BIT_DEC_MEASURING 10
`define BIT_DEC_ARMED 9
`define BIT_ENC_AUX_INFO 8
`define BIT_ENC_INFO 7
`define BIT_COMM_SUMMARY 6
`define BIT_LIMIT_EXCEEDED 5
`define BIT_SELF_TEST_FAIL 4
`define BIT_OVERPOWER 3
`define BIT_UNUSED_2 2
`define BIT_MIC_KEYED 1
`define BIT_BATTERY_LOW 0

// reset values
`define RST_RISE 16'hffff
`define RST_FALL 16'h0000
`define RST_EVNT 16'h0000
`define RST_MASK 16'h0000

`endif

// [hw_status_pkg.sv]
// types shared by the first equipment status group
package hw_status_pkg;
    // command port state: idle or a query answer pending
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_ANSWER = 1'b1
    } resp_state_e;
    // encoder mode
    typedef enum logic [1:0] {
        ENC_ONE_FIELD = 2'b00,
        ENC_TWO_FIELD = 2'b01,
        ENC_FUNC_GEN = 2'b10
    } enc_mode_e;
endpackage

// [cond_mapper.sv]
// maps live hardware conditions onto the 16 condition bits
`timescale 1ns/1ns
`default_nettype none
`include "hw_status_consts.svh"
module cond_mapper
    import hw_status_pkg::*;
(
    // radio interface cards
    input wire logic radio_irq1,
    input wire logic radio_irq2,
    // signaling decoder
    input wire logic dec_results,
    input wire logic dec_low_level,
    input wire logic dec_measuring,
    input wire logic dec_armed,
    // signaling encoder
    input wire logic [1:0] enc_mode,
    input wire logic [1:0] enc_fields_sent,
    // other conditions
    input wire logic comm_summary,
    input wire logic limit_exceeded,
    input wire logic self_test_fail,
    input wire logic overpower,
    input wire logic mic_keyed,
    input wire logic battery_low,
    // mapped word
    output logic [`STAT_WIDTH-1:0] cond
);
    // field counts decoded from the encoder mode
    logic two_field;
    logic func_gen;
    assign two_field = (enc_mode_e'(enc_mode) == ENC_TWO_FIELD);
    assign func_gen = (enc_mode_e'(enc_mode) == ENC_FUNC_GEN);

    // purely combinational map; registering happens in the group
    always_comb
    begin
        cond = '0;
        cond[`BIT_ALWAYS_ZERO] = 1'b0;
        cond[`BIT_RADIO_IRQ2] = radio_irq2;
        cond[`BIT_RADIO_IRQ1] = radio_irq1;
        cond[`BIT_DEC_RESULTS] = dec_results;
        cond[`BIT_DEC_LOW_LEVEL] = dec_low_level;
        cond[`BIT_DEC_MEASURING] = dec_measuring;
        cond[`BIT_DEC_ARMED] = dec_armed;
        // both fields of a two-field mode going out
        cond[`BIT_ENC_AUX_INFO] = two_field && (enc_fields_sent == 2'h2);
        // one field out, never in function generator mode
        cond[`BIT_ENC_INFO] = !func_gen && (enc_fields_sent == 2'h1);
        cond[`BIT_COMM_SUMMARY] = comm_summary;
        cond[`BIT_LIMIT_EXCEEDED] = limit_exceeded;
        cond[`BIT_SELF_TEST_FAIL] = self_test_fail;
        cond[`BIT_OVERPOWER] = overpower;
        cond[`BIT_UNUSED_2] = 1'b0;
        cond[`BIT_MIC_KEYED] = mic_keyed;
        cond[`BIT_BATTERY_LOW] = battery_low;
    end
endmodule
`default_nettype wire

// [hw_status_group.sv]
// first equipment status group: condition, transition filters, event, mask and summary
// Functional notes
// - all registers 16 bits, one summary
// - event clears on query or clear-status
// - mask cleared only by reset or by writing zero
// - both filters readable and writable by command
// - mask writable and readable by command
// - condition query returns live bits, no effect
// - event query returns bits, then clears
// - condition bit 15 always zero
// - bits 14/13 radio card interrupts
// - bits 12..9 signaling decoder state
// - bit 8 both fields being sent
// - bit 7 single field being sent
// - bit 7 off in function generator
// - bit 6 communication group summary
// - bit 5 measurement limit exceeded
// - bit 4 self test, bit 3 overpower
// - bit 2 unused, mic keyed, battery low
`timescale 1ns/1ns
`default_nettype none
`include "hw_status_consts.svh"
module hw_status_group
    import hw_status_pkg::*;
#(
    parameter int WIDTH = `STAT_WIDTH
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // status command port
    input wire logic cmd_valid,
    input wire logic [2:0] cmd_code,
    input wire logic [WIDTH-1:0] cmd_data,
    input wire logic clear_status,
    // query answer
    output logic resp_valid,
    output logic [WIDTH-1:0] resp_data,
    // hardware conditions
    input wire logic radio_irq1,
    input wire logic radio_irq2,
    input wire logic dec_results,
    input wire logic dec_low_level,
    input wire logic dec_measuring,
    input wire logic dec_armed,
    input wire logic [1:0] enc_mode,
    input wire logic [1:0] enc_fields_sent,
    input wire logic comm_summary,
    input wire logic limit_exceeded,
    input wire logic self_test_fail,
    input wire logic overpower,
    input wire logic mic_keyed,
    input wire logic battery_low,
    // group summary message
    output logic summary
);
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [WIDTH-1:0] cond_live; // mapped live conditions
    logic [WIDTH-1:0] cond_r; // registered condition word
    logic [WIDTH-1:0] cond_prev_r; // previous cycle, for edges
    logic [WIDTH-1:0] rise_r; // rising_edge_filter
    logic [WIDTH-1:0] fall_r; // falling_edge_filter
    logic [WIDTH-1:0] evnt_r; // latched_events
    logic [WIDTH-1:0] evnt_nxt;
    logic [WIDTH-1:0] mask_r; // summary_mask
    logic [WIDTH-1:0] edge_set; // new events this cycle
    logic prev_valid_r; // edges only after first sample
    resp_state_e state_r;
    logic rd_evnt; // event query this cycle

    // ------------------------------------------------------------
    // condition mapping
    // ------------------------------------------------------------
    cond_mapper u_map (
        .radio_irq1(radio_irq1),
        .radio_irq2(radio_irq2),
        .dec_results(dec_results),
        .dec_low_level(dec_low_level),
        .dec_measuring(dec_measuring),
        .dec_armed(dec_armed),
        .enc_mode(enc_mode),
        .enc_fields_sent(enc_fields_sent),
        .comm_summary(comm_summary),
        .limit_exceeded(limit_exceeded),
        .self_test_fail(self_test_fail),
        .overpower(overpower),
        .mic_keyed(mic_keyed),
        .battery_low(battery_low),
        .cond(cond_live)
    );

    // sample conditions once so edge detection sees a stable pair
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cond_r <= '0;
            cond_prev_r <= '0;
            prev_valid_r <= 1'b0;
        end
        else
        begin
            cond_r <= cond_live;
            // first sample after reset seeds the previous word too, so reset zeros never look like an edge
            cond_prev_r <= prev_valid_r ? cond_r : cond_live;
            prev_valid_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // transition filters and event latching
    // ------------------------------------------------------------
    // one generate lane per bit keeps the filter logic obvious
    for (genvar i = 0; i < WIDTH; i++)
    begin : g_edge
        assign edge_set[i] = prev_valid_r &&
            ((rise_r[i] && cond_r[i] && !cond_prev_r[i]) ||
             (fall_r[i] && !cond_r[i] && cond_prev_r[i]));
    end

    assign rd_evnt = cmd_valid && (cmd_code == `CMD_RD_EVNT);

    // clear first, then set: an edge in the clearing cycle survives
    always_comb
    begin
        evnt_nxt = evnt_r;
        if (rd_evnt || clear_status)
        begin
            evnt_nxt = '0;
        end
        evnt_nxt = evnt_nxt | edge_set;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            evnt_r <= `RST_EVNT;
        else
            evnt_r <= evnt_nxt;
    end

    // ------------------------------------------------------------
    // writable registers
    // ------------------------------------------------------------
    // filters and mask take the whole written word
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rise_r <= `RST_RISE;
            fall_r <= `RST_FALL;
            mask_r <= `RST_MASK;
        end
        else if (cmd_valid)
        begin
            case (cmd_code)
                `CMD_WR_RISE: rise_r <= cmd_data;
                `CMD_WR_FALL: fall_r <= cmd_data;
                // mask only changes on write; zero is the only clear
                `CMD_WR_MASK: mask_r <= cmd_data;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // query answers
    // ------------------------------------------------------------
    // answer is one cycle after the query; event value is pre-clear
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_r <= ST_IDLE;
            resp_data <= '0;
        end
        else
        begin
            state_r <= ST_IDLE;
            if (cmd_valid)
            begin
                case (cmd_code)
                    `CMD_RD_COND:
                    begin
                        resp_data <= cond_r;
                        state_r <= ST_ANSWER;
                    end
                    `CMD_RD_RISE:
                    begin
                        resp_data <= rise_r;
                        state_r <= ST_ANSWER;
                    end
                    `CMD_RD_FALL:
                    begin
                        resp_data <= fall_r;
                        state_r <= ST_ANSWER;
                    end
                    `CMD_RD_EVNT:
                    begin
                        resp_data <= evnt_r;
                        state_r <= ST_ANSWER;
                    end
                    `CMD_RD_MASK:
                    begin
                        resp_data <= mask_r;
                        state_r <= ST_ANSWER;
                    end
                    default: ;
                endcase
            end
        end
    end

    assign resp_valid = (state_r == ST_ANSWER);

    // ------------------------------------------------------------
    // summary message
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            summary <= 1'b0;
        else
            summary <= |(evnt_nxt & mask_r);
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_bit15_zero: assert property (@(posedge clk) disable iff (!rst_n)
        !cond_r[`BIT_ALWAYS_ZERO])
        else $error("condition bit 15 not zero");

    a_evnt_rd_clear: assert property (@(posedge clk) disable iff (!rst_n)
        rd_evnt |=> ((evnt_r & ~$past(edge_set)) == '0))
        else $error("event not cleared by query");

    a_cls_clear: assert property (@(posedge clk) disable iff (!rst_n)
        clear_status |=> ((evnt_r & ~$past(edge_set)) == '0))
        else $error("event not cleared by clear status");

    a_evnt_rd_value: assert property (@(posedge clk) disable iff (!rst_n)
        rd_evnt |=> (resp_valid && resp_data == $past(evnt_r)))
        else $error("event query returned wrong value");

    a_cond_rd_value: assert property (@(posedge clk) disable iff (!rst_n)
        (cmd_valid && cmd_code == `CMD_RD_COND) |=> (resp_valid && resp_data == $past(cond_r)))
        else $error("condition query wrong");

    a_mask_hold: assert property (@(posedge clk) disable iff (!rst_n)
        !(cmd_valid && cmd_code == `CMD_WR_MASK) |=> mask_r == $past(mask_r))
        else $error("mask changed without write");

    a_mask_write: assert property (@(posedge clk) disable iff (!rst_n)
        (cmd_valid && cmd_code == `CMD_WR_MASK) |=> mask_r == $past(cmd_data))
        else $error("mask write lost");

    a_rise_write: assert property (@(posedge clk) disable iff (!rst_n)
        (cmd_valid && cmd_code == `CMD_WR_RISE) |=> rise_r == $past(cmd_data))
        else $error("rising filter write lost");

    a_edge_latch: assert property (@(posedge clk) disable iff (!rst_n)
        (prev_valid_r && (rise_r & cond_r & ~cond_prev_r) != '0) |=>
        (evnt_r & $past(rise_r & cond_r & ~cond_prev_r)) == $past(rise_r & cond_r & ~cond_prev_r))
        else $error("rising edge not latched");

    a_summary_or: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 summary == |($past(evnt_nxt) & $past(mask_r)))
        else $error("summary mismatch");

    a_info_fgen: assert property (@(posedge clk) disable iff (!rst_n)
        (enc_mode_e'(enc_mode) == ENC_FUNC_GEN) |=> !cond_r[`BIT_ENC_INFO])
        else $error("info bit active in function generator");

    a_fall_write: assert property (@(posedge clk) disable iff (!rst_n)
        (cmd_valid && cmd_code == `CMD_WR_FALL) |=> fall_r == $past(cmd_data))
        else $error("falling filter write lost");

    a_fall_latch: assert property (@(posedge clk) disable iff (!rst_n)
        (prev_valid_r && (fall_r & ~cond_r & cond_prev_r) != '0) |=>
        (evnt_r & $past(fall_r & ~cond_r & cond_prev_r)) == $past(fall_r & ~cond_r & cond_prev_r))
        else $error("falling edge not latched");

    // writes never produce an answer strobe
    a_write_quiet: assert property (@(posedge clk) disable iff (!rst_n)
        (cmd_valid && (cmd_code == `CMD_WR_RISE || cmd_code == `CMD_WR_FALL || cmd_code == `CMD_WR_MASK)) |=> !resp_valid)
        else $error("write produced an answer");

    // a condition query must leave the event register alone
    a_cond_rd_pure: assert property (@(posedge clk) disable iff (!rst_n)
        (cmd_valid && cmd_code == `CMD_RD_COND && !clear_status) |=> evnt_r == ($past(evnt_r) | $past(edge_set)))
        else $error("condition query altered events");

    c_event_query: cover property (@(posedge clk) disable iff (!rst_n)
        rd_evnt && evnt_r != '0);
    c_summary_high: cover property (@(posedge clk) disable iff (!rst_n)
        $rose(summary));
    c_fall_event: cover property (@(posedge clk) disable iff (!rst_n)
        (fall_r & ~cond_r & cond_prev_r) != '0);
    c_set_on_clear: cover property (@(posedge clk) disable iff (!rst_n)
        clear_status && edge_set != '0);
endmodule
`default_nettype wire

// [status_ctrl_model.sv]
// remote controller model that issues status commands to the group
`timescale 1ns/1ns
`default_nettype none
`include "hw_status_consts.svh"
module status_ctrl_model
(
    // clock
    input wire logic clk,
    // command side
    output logic cmd_valid,
    output logic [`STAT_WIDTH-1:0] cmd_data,
    output logic [2:0] cmd_code,
    output logic clear_status,
    // answer side
    input wire logic resp_valid,
    input wire logic [`STAT_WIDTH-1:0] resp_data
);
    // --------------------------------------------------------
    // idle levels at time zero
    // --------------------------------------------------------
    initial
    begin
        cmd_valid = 1'b0;
        cmd_code = 3'h0;
        cmd_data = 16'ha5a5;
        clear_status = 1'b0;
    end
    // one strobe per command; the answer is taken half a cycle after the taking edge
    task automatic send(input logic [2:0] code, input logic [15:0] data, output logic vld, output logic [15:0] rd);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_code = code;
        cmd_data = data;
        @(negedge clk);
        cmd_valid = 1'b0;
        // released data is inverted so a stale word cannot pass as valid
        cmd_data = ~data;
        vld = resp_valid;
        rd = resp_data;
    endtask
    // switches every summary contribution off by writing a zero mask
    task automatic mask_off();
        logic v;
        logic [15:0] d;
        send(`CMD_WR_MASK, 16'h0000, v, d);
    endtask
    // common clear-status command, a one-cycle pulse
    task automatic clear();
        @(negedge clk);
        clear_status = 1'b1;
        @(negedge clk);
        clear_status = 1'b0;
    endtask
endmodule
`default_nettype wire

// [hw_status_group_one_test.sv]
// self-checking bench for the first equipment status group
`timescale 1ns/1ns
`default_nettype none
`include "hw_status_consts.svh"
module hw_status_group_one_test
    import hw_status_pkg::*;
;
    // --------------------------------------------------------
    // signals
    // --------------------------------------------------------
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cmd_valid;
    logic [2:0] cmd_code;
    logic [15:0] cmd_data;
    logic clear_status;
    logic resp_valid;
    logic [15:0] resp_data;
    logic summary;
    logic [16:0] stim = 17'h00000; // hardware inputs: mode 16:15, fields 8:7
    integer seed = 32'h86cafab8;
    int miscompares = 0;
    int check_count = 0;
    logic [15:0] regs [3]; // rising filter, falling filter, mask
    logic [15:0] prev_c;
    logic [15:0] c;
    logic [15:0] ev;
    logic [31:0] r;
    // hand-written encoder corners ahead of the random words
    logic [16:0] corner [5] = '{17'h17eff, 17'h00080, 17'h08100, 17'h08080, 17'h00000};
    // clock at 125 MHz
    always #4 clk = ~clk;
    // --------------------------------------------------------
    // design and controller
    // --------------------------------------------------------
    hw_status_group DUT (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_data(cmd_data), .clear_status(clear_status), .resp_valid(resp_valid), .resp_data(resp_data),
        .radio_irq1(stim[13]), .radio_irq2(stim[14]), .dec_results(stim[12]), .dec_low_level(stim[11]),
        .dec_measuring(stim[10]), .dec_armed(stim[9]), .enc_mode(stim[16:15]), .enc_fields_sent(stim[8:7]),
        .comm_summary(stim[6]), .limit_exceeded(stim[5]), .self_test_fail(stim[4]), .overpower(stim[3]),
        .mic_keyed(stim[1]), .battery_low(stim[0]), .summary(summary));
    status_ctrl_model ctl (.clk(clk), .cmd_valid(cmd_valid), .cmd_data(cmd_data), .cmd_code(cmd_code),
        .clear_status(clear_status), .resp_valid(resp_valid), .resp_data(resp_data));
    // --------------------------------------------------------
    // expectations and comparisons
    // --------------------------------------------------------
    // condition word expected from the hardware inputs
    function automatic logic [15:0] exp_cond(input logic [16:0] s);
        logic [15:0] w;
        w = {1'b0, s[14:9], 2'b00, s[6:3], 1'b0, s[1:0]};
        w[8] = (s[16:15] == ENC_TWO_FIELD) && (s[8:7] == 2'd2);
        w[7] = (s[8:7] == 2'd1) && (s[16:15] != ENC_FUNC_GEN);
        return w;
    endfunction
    task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_flag(input logic got, input logic exp);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // a query must answer the cycle after it is taken
    task automatic query(input logic [2:0] code, input logic [15:0] exp);
        logic v;
        logic [15:0] d;
        ctl.send(code, 16'h0000, v, d);
        check_flag(v, 1'b1);
        check_word(d, exp);
    endtask
    // a write must not answer
    task automatic write(input logic [2:0] code, input logic [15:0] data);
        logic v;
        logic [15:0] d;
        ctl.send(code, data, v, d);
        check_flag(v, 1'b0);
    endtask
    // reset values of the summary and of every readable register except the condition
    task automatic check_resets();
        check_flag(summary, 1'b0);
        query(`CMD_RD_RISE, `RST_RISE);
        query(`CMD_RD_FALL, `RST_FALL);
        query(`CMD_RD_EVNT, `RST_EVNT);
        query(`CMD_RD_MASK, `RST_MASK);
        $display("test reset values done");
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // --------------------------------------------------------
    // watchdog, well beyond the expected run
    // --------------------------------------------------------
    initial
    begin
        #400000;
        miscompares++;
        complete_run();
    end
    // --------------------------------------------------------
    // main sequence
    // --------------------------------------------------------
    initial
    begin
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        check_resets();
        prev_c = 16'h0000;
        for (int i = 0; i < 40; i++)
        begin
            // new filters and mask every fourth pass, read straight back
            if (i % 4 == 0)
                for (int k = 0; k < 3; k++)
                begin
                    regs[k] = 16'($random(seed));
                    write(k == 0 ? `CMD_WR_RISE : k == 1 ? `CMD_WR_FALL : `CMD_WR_MASK, regs[k]);
                    query(k == 0 ? `CMD_RD_RISE : k == 1 ? `CMD_RD_FALL : `CMD_RD_MASK, regs[k]);
                end
            // mode and field count stay within the values the design accepts
            r = $random(seed);
            @(negedge clk);
            stim = i < 5 ? corner[i] : {2'(r[31:24] % 8'd3), r[14:9], 2'(r[23:16] % 8'd3), r[6:0]};
            repeat (3) @(negedge clk);
            c = exp_cond(stim);
            ev = (~prev_c & c & regs[0]) | (prev_c & ~c & regs[1]);
            check_flag(summary, |(ev & regs[2]));
            query(`CMD_RD_COND, c);
            if (i % 2 == 1)
                query(`CMD_RD_EVNT, ev);
            else
                ctl.clear();
            query(`CMD_RD_EVNT, 16'h0000);
            prev_c = c;
        end
        $display("test conditions and events done");
        // zero mask: events still latch but never reach the summary
        ctl.mask_off();
        query(`CMD_RD_MASK, 16'h0000);
        @(negedge clk);
        stim = {2'b00, ~prev_c[14:9], 2'b00, ~prev_c[6:0]};
        repeat (3) @(negedge clk);
        check_flag(summary, 1'b0);
        $display("test mask off done");
        // second reset in mid-run
        rst_n = 1'b0;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        check_resets();
        query(`CMD_RD_COND, exp_cond(stim));
        complete_run();
    end
endmodule
`default_nettype wire
